// *** design/regulator_sleep_wake_timer.sv ***
// Overview of operation
// - settings 1-16 give setting times 250 ms
// - settings 17-255 use one-second steps, 5..243 s
// - setting zero disables the timer entirely
// - non-zero setting write starts the timer
// - off-on-start bit switches regulator off after delay
// - expiry restores regulator per control setting
// - delay select 0/250ms/1s/4s before switching off
// - alarm wake re-enables regulator early when enabled
// - wake, delay and off-on-start bits reset zero
//
// The Avalon-MM register port and the address map were chosen for this implementation.
module regulator_sleep_wake_timer
   import wake_timer_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = QUARTER_CYCLES,
   parameter int unsigned ALARM_W     = 16
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // avalon-mm slave
   input  wire logic [3:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   input  wire logic [3:0]          byteenable,
   output logic      [31:0]         readdata,
   output logic                     waitrequest,
   // device side
   input  wire logic [ALARM_W-1:0]  alarm_flags,
   input  wire logic                ldo_control_setting,
   output logic                     switched_ldo_output
);
   import wake_timer_pkg::*;

   // bus handshake state
   logic              ack_q;       // answer cycle flag
   logic              ack_d;
   logic [31:0]       rdata_q;     // registered read data
   logic [31:0]       rdata_d;
   logic              req;         // any request pending
   logic              wr_take;     // write taken this edge
   logic              ctrl_wr;     // write to control word
   logic              set_wr;      // setting byte written

   // control register and merged write value
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic [CTRL_W-1:0] ctrl_new;

   // sequence state
   state_t            state_q;
   state_t            state_d;
   logic [CNT_W-1:0]  count_q;     // quarters left to expiry
   logic [CNT_W-1:0]  count_d;
   logic [DLY_CNT_W-1:0] dly_q;   // quarters left to switch-off
   logic [DLY_CNT_W-1:0] dly_d;
   logic              ldo_on_q;    // regulator enable
   logic              ldo_on_d;

   // helpers
   logic              tick;        // quarter-second pulse
   logic              restart;     // realign time base
   logic [CNT_W-1:0]  new_quarters;
   logic [DLY_CNT_W-1:0] new_dly;
   logic              expire;      // countdown reaches zero
   logic              alarm_wake;  // early wake request
   logic              new_sd;
   logic [SET_W-1:0]  new_set;

   // bus request decode
   assign req         = read | write;
   assign waitrequest = req & ~ack_q;
   assign wr_take     = write & ack_q;
   assign ctrl_wr     = wr_take & (address == CTRL_OFS);
   assign set_wr      = ctrl_wr & byteenable[0];

   // merge written lanes into control word
   always_comb begin
      ctrl_new = ctrl_q;
      if (byteenable[0]) begin
         ctrl_new[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
         ctrl_new[15:8] = writedata[15:8];
      end
      ctrl_new = ctrl_new & CTRL_MASK;
   end

   assign new_set = ctrl_new[SET_LSB +: SET_W];
   assign new_sd  = ctrl_new[SD_BIT];

   // slow time base, realigned on each start
   quarter_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk     (clk),
      .rst_b   (rst_b),
      .restart (restart),
      .tick    (tick)
   );

   // setting to quarter counts
   // fine and coarse steps decoded
   timeout_decode u_decode (
      .setting  (new_set),
      .quarters (new_quarters)
   );

   // delay select decode
   // delay table
   always_comb begin
      unique case (ctrl_new[DLY_LSB +: DLY_W])
         2'h0:    new_dly = DLY_Q0;
         2'h1:    new_dly = DLY_Q1;
         2'h2:    new_dly = DLY_Q2;
         default: new_dly = DLY_Q3;
      endcase
   end

   assign expire     = tick & (count_q == CNT_W'(1));
   assign alarm_wake = ctrl_q[WAKE_BIT] & ctrl_q[SD_BIT]
                     & (|alarm_flags);
   assign restart    = set_wr & (new_set != 8'h00);

   // bus next values: one wait cycle, then answer
   always_comb begin
      ack_d   = req & ~ack_q;
      rdata_d = rdata_q;
      ctrl_d  = ctrl_q;
      if (req && !ack_q && read) begin
         rdata_d = 32'h0000_0000;
         if (address == CTRL_OFS) begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
         end else if (address == STAT_OFS) begin
            rdata_d[STAT_RUN_BIT]  = (state_q != ST_IDLE);
            rdata_d[STAT_OFF_BIT]  = (state_q == ST_OFF);
            rdata_d[STAT_WAIT_BIT] = (state_q == ST_WAIT_OFF);
            rdata_d[STAT_LDO_BIT]  = ldo_on_q;
            rdata_d[STAT_CNT_LSB +: CNT_W] = count_q;
         end
      end
      if (ctrl_wr) begin
         ctrl_d = ctrl_new;
      end
   end

   // bus registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q  <= CTRL_RESET;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q  <= ctrl_d;
      end
   end

   assign readdata = rdata_q;

   // sequence next values
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      dly_d   = dly_q;
      // countdown while running
      if (tick && state_q != ST_IDLE && count_q != '0) begin
         count_d = count_q - CNT_W'(1);
      end
      if (set_wr) begin
         if (new_set == 8'h00) begin
            state_d = ST_IDLE;
            count_d = '0;
            dly_d   = '0;
         end else begin
            count_d = new_quarters;
            dly_d   = new_dly;
            if (!new_sd) begin
               state_d = ST_RUN;
            end else if (ldo_on_q && new_dly != DLY_Q0) begin
               state_d = ST_WAIT_OFF;
            end else begin
               state_d = ST_OFF;
            end
         end
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // nothing running
               state_d = ST_IDLE;
            end
            ST_RUN: begin
               // plain countdown
               if (expire) begin
                  state_d = ST_IDLE;
               end
            end
            ST_WAIT_OFF: begin
               // delay runs beside the timeout
               if (tick && dly_q != '0) begin
                  dly_d = dly_q - DLY_CNT_W'(1);
               end
               if (expire || alarm_wake) begin
                  state_d = ST_IDLE;
               end else if (tick && dly_q == DLY_CNT_W'(1)) begin
                  state_d = ST_OFF;
               end
            end
            ST_OFF: begin
               if (expire || alarm_wake) begin
                  state_d = ST_IDLE;
               end
            end
            default: begin
               // illegal code recovers to idle
               state_d = ST_IDLE;
               count_d = '0;
               dly_d   = '0;
            end
         endcase
      end
      // regulator follows its control setting unless off
      ldo_on_d = (state_d != ST_OFF) & ldo_control_setting;
   end

   // sequence registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q  <= ST_IDLE;
         count_q  <= '0;
         dly_q    <= '0;
         ldo_on_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         count_q  <= count_d;
         dly_q    <= dly_d;
         ldo_on_q <= ldo_on_d;
      end
   end

   assign switched_ldo_output = ldo_on_q;

   // checks on the sequence
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_fine_load: assert property (
      set_wr && new_set != 8'h00 && new_set <= 8'h10
      |=> count_q == CNT_W'($past(new_set)))
      else $error("fine setting loaded wrong count");

   a_coarse_load: assert property (
      set_wr && new_set > 8'h10
      |=> count_q == CNT_W'(({2'b00, $past(new_set)} - 10'd12) * 4))
      else $error("coarse setting loaded wrong count");

   a_zero_stops: assert property (
      set_wr && new_set == 8'h00
      |=> state_q == ST_IDLE && count_q == '0 ##1 state_q == ST_IDLE)
      else $error("zero setting did not stop timer");

   a_write_starts: assert property (
      set_wr && new_set != 8'h00 |=> state_q != ST_IDLE)
      else $error("non-zero setting did not start timer");

   a_off_holds: assert property (
      state_q == ST_OFF |-> !switched_ldo_output)
      else $error("regulator on while switched off");

   a_run_keeps: assert property (
      state_q == ST_RUN && state_d == ST_RUN
      |=> switched_ldo_output == $past(ldo_control_setting))
      else $error("regulator disturbed without off-on-start");

   a_expiry_wakes: assert property (
      state_q == ST_OFF && expire && !set_wr
      |=> state_q == ST_IDLE
          && switched_ldo_output == $past(ldo_control_setting))
      else $error("expiry did not restore regulator");

   a_nodelay_off: assert property (
      set_wr && new_set != 8'h00 && new_sd && new_dly == DLY_Q0
      |=> state_q == ST_OFF ##0 !switched_ldo_output)
      else $error("zero delay did not switch off at once");

   a_alarm_wake: assert property (
      state_q == ST_OFF && alarm_wake && !set_wr |=> state_q == ST_IDLE)
      else $error("alarm did not wake regulator");

   a_no_alarm: assert property (
      state_q == ST_OFF && !ctrl_q[WAKE_BIT] && !tick && !set_wr
      |=> state_q == ST_OFF)
      else $error("alarm woke regulator while disabled");

   a_reset_zero: assert property (
      $past(!rst_b) |-> ctrl_q[WAKE_BIT:SD_BIT] == 4'h0)
      else $error("option bits not clear after reset");

   a_tick_count: assert property (
      tick && state_q != ST_IDLE && count_q != '0 && !set_wr
      |=> count_q == $past(count_q) - CNT_W'(1))
      else $error("countdown did not follow tick");

   c_delay_seq: cover property (
      state_q == ST_WAIT_OFF ##1 state_q == ST_OFF);
   c_expiry: cover property (state_q == ST_OFF ##1 state_q == ST_IDLE);
   c_restart: cover property (state_q == ST_RUN && set_wr);
   c_read_stat: cover property (read && ack_q && address == STAT_OFS);
endmodule

// *** design/wake_timer_pkg.sv ***
package wake_timer_pkg;

   // register word offsets (byte addresses)
   localparam logic [3:0]  CTRL_OFS       = 4'h0;
   localparam logic [3:0]  STAT_OFS       = 4'h4;

   // control register field layout
   localparam int          SET_LSB        = 0;
   localparam int          SET_W          = 8;
   localparam int          SD_BIT         = 8;
   localparam int          DLY_LSB        = 9;
   localparam int          DLY_W          = 2;
   localparam int          WAKE_BIT       = 11;
   localparam int          CTRL_W         = 16;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] CTRL_MASK      = 16'h0fff;

   // status register field layout
   localparam int          STAT_RUN_BIT   = 0;
   localparam int          STAT_OFF_BIT   = 1;
   localparam int          STAT_WAIT_BIT  = 2;
   localparam int          STAT_LDO_BIT   = 3;
   localparam int          STAT_CNT_LSB   = 16;

   // countdown width in quarter seconds (243 s = 972 quarters)
   localparam int          CNT_W          = 10;
   localparam int          DLY_CNT_W      = 5;

   // time base
   localparam int          CLK_HZ         = 40_000_000;
   localparam int          QUARTER_MS     = 250;
   localparam int          QUARTER_CYCLES = CLK_HZ / 1000 * QUARTER_MS;

   // timeout encoding: fine steps up to 16, then one-second steps
   localparam logic [7:0]  FINE_LIMIT     = 8'h10;
   localparam logic [7:0]  COARSE_BASE    = 8'h0c;

   // shutdown delay in quarter seconds per select code
   localparam logic [4:0]  DLY_Q0         = 5'h00;
   localparam logic [4:0]  DLY_Q1         = 5'h01;
   localparam logic [4:0]  DLY_Q2         = 5'h04;
   localparam logic [4:0]  DLY_Q3         = 5'h10;

   // sequence states
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_RUN      = 4'b0010,
      ST_WAIT_OFF = 4'b0100,
      ST_OFF      = 4'b1000
   } state_t;

endpackage

// *** design/quarter_tick.sv ***
// free divider giving one pulse per quarter second, restartable
module quarter_tick #(
   parameter int unsigned CYCLES = 10
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // control
   input  wire logic restart,
   // one-cycle pulse per period
   output logic      tick
);
   localparam int W = $clog2(CYCLES) + 1;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_q;  // cycles into the period
   logic [W-1:0] cnt_d;
   logic         tick_q; // registered pulse
   logic         tick_d;

   // next count: restart aligns a full first period
   always_comb begin
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = '0;
      end else if (cnt_q == LAST) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + W'(1);
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule

// *** design/timeout_decode.sv ***
// maps the 8-bit timeout setting to quarter-second counts
module timeout_decode (
   // setting in
   input  wire logic [wake_timer_pkg::SET_W-1:0] setting,
   // length in quarter seconds
   output logic      [wake_timer_pkg::CNT_W-1:0] quarters
);
   import wake_timer_pkg::*;

   // two-segment decode of the setting
   always_comb begin
      if (setting <= FINE_LIMIT) begin
         quarters = {2'b00, setting};
      end else begin
         // one-second steps, 17 -> 5 s
         quarters = {setting - COARSE_BASE, 2'b00};
      end
   end
endmodule

// *** bench/avalon_host.sv ***
// host side of the register bus: one request at a time
module avalon_host (
   // clock
   input  wire logic        clk,
   // avalon-mm master outputs
   output logic [3:0]       address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   output logic [3:0]       byteenable,
   // slave answer
   input  wire logic        waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;

   bit lost = 1'b0; // an answer never came

   // bus idle from time zero
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
   end

   // hold the request until waitrequest is seen low at an edge
   task automatic finish_req();
      int i;
      for (i = 0; i < 64; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      if (i == 64) lost = 1'b1;
   endtask

   // one write, released only after the accepting edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= 1'b1;
      finish_req();
      write <= 1'b0;
   endtask

   // one read; data is taken by the bench monitor
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      finish_req();
      read <= 1'b0;
   endtask
endmodule

// *** bench/regulator_sleep_wake_timer_tb.sv ***
module regulator_sleep_wake_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wake_timer_pkg::*;

   localparam int unsigned TICK = 4; // short quarter second
   localparam logic [7:0]  TBL [4] = '{8'h01, 8'h10, 8'h11, 8'hff};

   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [15:0] alarm_flags = 16'h0;
   logic        ldo_control_setting = 1'b1;
   logic        switched_ldo_output;
   int          n_errors = 0;
   int          n_compared = 0;
   logic [31:0] exp_q [$]; // expected read words
   logic [31:0] msk_q [$]; // bits that are compared

   // 40 mhz clock
   always #12.5 clk = ~clk;

   regulator_sleep_wake_timer #(.TICK_CYCLES(TICK), .ALARM_W(16)) dut (
      .clk(clk), .rst_b(rst_b), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .alarm_flags(alarm_flags),
      .ldo_control_setting(ldo_control_setting),
      .switched_ldo_output(switched_ldo_output));

   avalon_host host (
      .clk(clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .waitrequest(waitrequest));

   // report one mismatch
   task automatic err(input string m);
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   // verdict and end of run
   task automatic end_of_test();
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // note the expected word, then issue the read
   task automatic expect_rd(input logic [3:0] a, input logic [31:0] e,
                            input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      host.rd(a);
   endtask

   // regulator level k edges later
   task automatic chk_ldo(input int k, input logic e);
      repeat (k) @(posedge clk);
      #1;
      n_compared++;
      if (switched_ldo_output !== e) err("regulator level wrong");
   endtask

   // status word: count and flag nibble
   function automatic logic [31:0] st(input logic [9:0] c,
                                      input logic [3:0] f);
      return {6'h0, c, 12'h0, f};
   endfunction

   // take the oldest note off the queue at each read answer
   always @(posedge clk) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         n_compared++;
         if (exp_q.size() == 0)
            err("read without note");
         else if ((readdata & msk_q.pop_front()) !== exp_q.pop_front())
            err("read data mismatch");
      end
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      err("timeout");
      end_of_test();
   end

   // main sequence
   initial begin
      int s;
      int q;
      logic [9:0] c;
      void'($urandom(32'he5c6));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      // reset values and register access
      expect_rd(CTRL_OFS, 32'h0, 32'hffff_ffff);
      expect_rd(STAT_OFS, st(10'h0, 4'h8), 32'h0000_000f);
      host.wr(CTRL_OFS, 32'h0000_ffff, 4'h3);
      expect_rd(CTRL_OFS, 32'h0000_0fff, 32'hffff_ffff);
      host.wr(CTRL_OFS, 32'h0, 4'h3);
      host.wr(CTRL_OFS, 32'h0000_0f00, 4'h2);
      expect_rd(CTRL_OFS, 32'h0000_0f00, 32'hffff_ffff);
      host.wr(STAT_OFS, 32'hffff_ffff, 4'hf);
      expect_rd(STAT_OFS, st(10'h0, 4'h8), 32'h0000_000f);
      host.wr(4'h8, 32'hffff_ffff, 4'hf);
      expect_rd(4'h8, 32'h0, 32'hffff_ffff);
      expect_rd(CTRL_OFS, 32'h0000_0f00, 32'hffff_ffff);
      // encodings, back-to-back restarts, random settings
      for (int i = 0; i < 8; i++) begin
         s = (i < 4) ? int'(TBL[i]) : 1 + $urandom % 255;
         c = (s <= 16) ? 10'(s) : 10'((s - 12) * 4);
         host.wr(CTRL_OFS, 32'(s), 4'h3);
         expect_rd(STAT_OFS, st(c, 4'h9), 32'h03ff_000f);
      end
      host.wr(CTRL_OFS, 32'h0, 4'h3);
      expect_rd(STAT_OFS, st(10'h0, 4'h8), 32'h0000_000f);
      // shutdown at once, back on at expiry
      host.wr(CTRL_OFS, 32'h0000_0103, 4'h3);
      chk_ldo(2, 1'b0);
      chk_ldo(10, 1'b0);
      chk_ldo(3, 1'b1);
      // each non-zero shutdown delay code
      for (int d = 1; d < 4; d++) begin
         q = (d == 1) ? 1 : (d == 2) ? 4 : 16;
         host.wr(CTRL_OFS, 32'h0000_01ff | (d << 9), 4'h3);
         expect_rd(STAT_OFS, 32'hd, 32'h0000_000f);
         chk_ldo(4 * q - 4, 1'b1);
         chk_ldo(5, 1'b0);
         host.wr(CTRL_OFS, 32'h0, 4'h3);
         chk_ldo(2, 1'b1);
      end
      // no shutdown when the bit is clear
      host.wr(CTRL_OFS, 32'h0000_0602, 4'h3);
      chk_ldo(3, 1'b1);
      chk_ldo(10, 1'b1);
      // alarm wake disabled, then enabled
      for (int w = 0; w < 2; w++) begin
         host.wr(CTRL_OFS, 32'h0000_01ff | (w << 11), 4'h3);
         chk_ldo(2, 1'b0);
         @(posedge clk);
         alarm_flags <= 16'h1 << ($urandom % 16);
         chk_ldo(3, w[0]);
         expect_rd(STAT_OFS, w ? 32'h8 : 32'h3, 32'h0000_000f);
         alarm_flags <= 16'h0;
         host.wr(CTRL_OFS, 32'h0, 4'h3);
      end
      // idle regulator follows its own setting
      @(posedge clk);
      ldo_control_setting <= 1'b0;
      chk_ldo(3, 1'b0);
      repeat (4) @(posedge clk);
      n_compared++;
      if (host.lost !== 1'b0 || exp_q.size() != 0) err("bus answer missing");
      end_of_test();
   end
endmodule
